// >>> src/dcd_pkg.sv
// package of constants and types for the disk command decoder
package dcd_pkg;

    // command field positions
    localparam int unsigned RATE_LSB      = 0;
    localparam int unsigned VERIFY_BIT    = 2;
    localparam int unsigned HEAD_BIT      = 3;
    localparam int unsigned TRKUPD_BIT    = 4;
    localparam int unsigned MARK_BIT      = 0;
    localparam int unsigned SIDE_CMP_BIT  = 1;
    localparam int unsigned SETTLE_BIT    = 2;
    localparam int unsigned SIDE_NUM_BIT  = 3;
    localparam int unsigned MULTI_BIT     = 4;

    // command written at release of master reset
    localparam logic [7:0] RESET_CMD      = 8'h03;
    localparam logic [7:0] CMD_RESET_VAL  = 8'h00;

    // data address mark values
    localparam logic [7:0] MARK_NORMAL    = 8'hfb;
    localparam logic [7:0] MARK_DELETED   = 8'hf8;

    // sector lengths in bytes
    localparam logic [10:0] LEN_128       = 11'h080;
    localparam logic [10:0] LEN_256       = 11'h100;
    localparam logic [10:0] LEN_512       = 11'h200;
    localparam logic [10:0] LEN_1024      = 11'h400;

    // settle delay: 15 ms at the system clock rate
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned SETTLE_MS     = 15;
    localparam int unsigned SETTLE_CYC    = SETTLE_MS * (CLK_HZ / 1000);
    localparam int unsigned SETTLE_W      = 20;

    // command kinds
    typedef enum logic [3:0] {
        CMD_RESTORE   = 4'b0000,
        CMD_SEEK      = 4'b0001,
        CMD_STEP      = 4'b0010,
        CMD_STEP_IN   = 4'b0011,
        CMD_STEP_OUT  = 4'b0100,
        CMD_RD_SECT   = 4'b0101,
        CMD_WR_SECT   = 4'b0110,
        CMD_RD_ADDR   = 4'b0111,
        CMD_RD_TRACK  = 4'b1000,
        CMD_WR_TRACK  = 4'b1001,
        CMD_FORCE     = 4'b1010,
        CMD_ILLEGAL   = 4'b1111
    } dcd_cmd_type;

    // command classes
    typedef enum logic [1:0] {
        CLS_ONE   = 2'b00,
        CLS_TWO   = 2'b01,
        CLS_THREE = 2'b10,
        CLS_FOUR  = 2'b11
    } dcd_class_type;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN    = 2'b10
    } dcd_state_type;

endpackage

// >>> src/dcd_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dcd_sync
    import dcd_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)(
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // first stage, read only by the second
    logic [WIDTH-1:0] meta_q;

    // two stages in series
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // dcd_sync

// >>> src/dcd_decoder.sv
// command acceptance, decoding, busy and interrupt logic
// Operation
// - busy held while command executes
// - completion raises interrupt, clears busy
// - status reports error or clean finish
// - decode restore, seek, step variants
// - decode sector, track, address, force
// - classify command into four types
// - type one rate from bits one, zero
// - bit two selects destination verify
// - bit three selects head load
// - bit four enables track update
// - write sector bit zero picks mark
// - bit one enables side compare
// - bit one drives side select output
// - bit two inserts settle delay
// - bit three gives expected side
// - bit three picks length code table
// - bit four selects multiple records
// - force bits arm interrupt conditions
// - force zero ends without interrupt
// - reset release runs restore command
// - not ready refuses type two, three
// - interrupt clears on status read, write; immediate force interrupt held until reset
`timescale 1ns/10ps
module dcd_decoder
    import dcd_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        side_variant,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        status_read,
    input  wire logic        op_done,
    input  wire logic        op_error,
    input  wire logic        ready_pin,
    input  wire logic        index_pin,
    input  wire logic [1:0]  id_length_code,
    output logic             busy,
    output logic             error_flag,
    output logic             interrupt_request_out,
    output logic             side_select_out,
    output logic             op_start,
    output dcd_cmd_type      cmd_kind,
    output dcd_class_type    cmd_class,
    output logic [1:0]       step_rate,
    output logic             verify_en,
    output logic             head_load,
    output logic             track_update,
    output logic [7:0]       data_mark_select,
    output logic             side_compare_en,
    output logic             side_expected,
    output logic             multi_record,
    output logic [10:0]      sector_bytes,
    output logic             not_ready_refused
);
    // decode the top bits of a command word
    function automatic dcd_cmd_type decode_cmd(input logic [7:0] c);
        dcd_cmd_type k;
        k = CMD_ILLEGAL;
        if (c[7:4] == 4'h0)
            k = CMD_RESTORE;
        else if (c[7:4] == 4'h1)
            k = CMD_SEEK;
        else if (c[7:5] == 3'h1)
            k = CMD_STEP;
        else if (c[7:5] == 3'h2)
            k = CMD_STEP_IN;
        else if (c[7:5] == 3'h3)
            k = CMD_STEP_OUT;
        else if (c[7:5] == 3'h4)
            k = CMD_RD_SECT;
        else if (c[7:5] == 3'h5)
            k = CMD_WR_SECT;
        else if (c[7:4] == 4'hd)
            k = CMD_FORCE;
        else if (c[7:3] == 5'h18)
            k = CMD_RD_ADDR;
        else if (c[7:3] == 5'h1c)
            k = CMD_RD_TRACK;
        else if (c[7:3] == 5'h1e)
            k = CMD_WR_TRACK;
        return k;
    endfunction

    // class of a decoded command
    function automatic dcd_class_type class_of(input dcd_cmd_type k);
        dcd_class_type c;
        c = CLS_ONE;
        if (k == CMD_RD_SECT || k == CMD_WR_SECT)
            c = CLS_TWO;
        else if (k == CMD_RD_ADDR || k == CMD_RD_TRACK || k == CMD_WR_TRACK)
            c = CLS_THREE;
        else if (k == CMD_FORCE)
            c = CLS_FOUR;
        return c;
    endfunction

    // synchronised pins
    logic       ready_s;        // drive ready
    logic       index_s;        // index pulse
    dcd_sync #(.WIDTH(2)) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({ready_pin, index_pin}),
        .sync_out ({ready_s, index_s})
    );

    // state and held registers
    dcd_state_type        state_q, state_d;     // sequencer
    logic [7:0]           cmd_q;                // latched command
    logic                 irq_q;                // interrupt request
    logic                 err_q;                // last completion error
    logic                 side_sel_q;           // side select
    logic                 boot_q;               // reset restore pending
    logic                 refused_q;            // last refusal
    logic [3:0]           arm_q;                // force conditions
    logic                 ready_q;              // ready history
    logic                 index_q;              // index history
    logic                 sticky_q;             // immediate interrupt latch
    logic [SETTLE_W-1:0]  settle_q;             // settle counter

    // incoming word decode
    dcd_cmd_type   in_kind;
    dcd_class_type in_class;
    assign in_kind  = decode_cmd(cmd_data);
    assign in_class = class_of(in_kind);

    // acceptance: idle, or force at any time
    wire is_force  = (in_kind == CMD_FORCE);
    wire take      = cmd_write && (state_q == ST_IDLE || is_force);
    wire needs_rdy = (in_class == CLS_TWO) || (in_class == CLS_THREE);
    wire refuse    = take && needs_rdy && !ready_s;
    wire launch    = (take && !is_force && !refuse) || boot_q;
    wire settle_en = cmd_data[SETTLE_BIT] && needs_rdy;
    wire settle_end = (settle_q == SETTLE_W'(SETTLE_CYC - 1));

    // armed condition events
    wire ev_to_rdy  = arm_q[0] && ready_s && !ready_q;
    wire ev_to_nrdy = arm_q[1] && !ready_s && ready_q;
    wire ev_index   = arm_q[2] && index_s && !index_q;
    wire ev_armed   = ev_to_rdy || ev_to_nrdy || ev_index;
    wire force_now  = take && is_force && cmd_data[3];
    wire done       = (state_q == ST_RUN) && op_done;
    wire irq_set    = done || refuse || ev_armed || force_now;
    wire irq_clr    = status_read || cmd_write;

    // sequencer next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (launch)
                    state_d = (settle_en && !boot_q) ? ST_SETTLE : ST_RUN;
            end
            ST_SETTLE:
            begin
                if (take && is_force)
                    state_d = ST_IDLE;
                else if (settle_end)
                    state_d = ST_RUN;
            end
            ST_RUN:
            begin
                if ((take && is_force) || op_done)
                    state_d = ST_IDLE;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // sequencer and command register
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_RESET_VAL;
            boot_q  <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            boot_q  <= 1'b0;
            if (boot_q)
                cmd_q <= RESET_CMD;
            else if (take && !refuse)
                cmd_q <= cmd_data;
        end
    end

    // settle counter runs only while settling
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            settle_q <= '0;
        else if (state_q == ST_SETTLE)
            settle_q <= settle_q + 1'b1;
        else
            settle_q <= '0;
    end

    // interrupt, error and sticky force latch; set wins over clear
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            irq_q     <= 1'b0;
            err_q     <= 1'b0;
            sticky_q  <= 1'b0;
            refused_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_set || sticky_q || (irq_q && !irq_clr);
            if (force_now)
                sticky_q <= 1'b1;
            if (done)
                err_q <= op_error;
            else if (refuse)
                err_q <= 1'b1;
            else if (launch)
                err_q <= 1'b0;
            if (take)
                refused_q <= refuse;
        end
    end

    // force arming, pin history and side select
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            arm_q   <= 4'h0;
            ready_q <= 1'b0;
            index_q <= 1'b0;
            side_sel_q <= 1'b0;
        end
        else
        begin
            ready_q <= ready_s;
            index_q <= index_s;
            if (take && is_force)
                arm_q <= cmd_data[3:0];
            if (launch && !boot_q && side_variant && needs_rdy)
                side_sel_q <= cmd_data[SIDE_CMP_BIT];
        end
    end

    // decoded outputs from the held command
    assign cmd_kind  = decode_cmd(cmd_q);
    assign cmd_class = class_of(cmd_kind);
    wire   c1 = (cmd_class == CLS_ONE);
    wire   c2 = (cmd_class == CLS_TWO);
    wire   stepper = (cmd_kind == CMD_STEP) || (cmd_kind == CMD_STEP_IN)
                     || (cmd_kind == CMD_STEP_OUT);
    assign step_rate    = c1 ? cmd_q[RATE_LSB +: 2] : 2'b00;
    assign verify_en    = c1 && cmd_q[VERIFY_BIT];
    assign head_load    = c1 && cmd_q[HEAD_BIT];
    assign track_update = stepper && cmd_q[TRKUPD_BIT];
    assign data_mark_select = (cmd_kind == CMD_WR_SECT && cmd_q[MARK_BIT])
                              ? MARK_DELETED : MARK_NORMAL;
    assign side_compare_en = c2 && !side_variant && cmd_q[SIDE_CMP_BIT];
    assign side_expected   = c2 && !side_variant && cmd_q[SIDE_NUM_BIT];
    assign multi_record    = c2 && cmd_q[MULTI_BIT];

    // sector length table, variant with length flag
    wire long_tbl = side_variant && c2 && cmd_q[SIDE_NUM_BIT];
    always_comb
    begin
        unique case (id_length_code)
            2'b00: sector_bytes = long_tbl ? LEN_128  : LEN_256;
            2'b01: sector_bytes = long_tbl ? LEN_256  : LEN_512;
            2'b10: sector_bytes = long_tbl ? LEN_512  : LEN_1024;
            2'b11: sector_bytes = long_tbl ? LEN_1024 : LEN_128;
        endcase
    end

    // status and handshake outputs
    assign busy                  = (state_q != ST_IDLE);
    assign error_flag            = err_q;
    assign interrupt_request_out = irq_q;
    assign side_select_out       = side_sel_q;
    assign op_start              = (state_q != ST_RUN) && (state_d == ST_RUN);
    assign not_ready_refused     = refused_q;

    // checks
    a_busy_after_launch: assert property (@(posedge sys_clk) disable iff (!reset_n)
        launch |=> busy) else $error("busy not set after launch");
    a_done_irq_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        done && !cmd_write |=> interrupt_request_out && !busy)
        else $error("completion missed irq or busy clear");
    a_error_reports: assert property (@(posedge sys_clk) disable iff (!reset_n)
        done |=> error_flag == $past(op_error)) else $error("error status wrong");
    a_refuse_irq: assert property (@(posedge sys_clk) disable iff (!reset_n)
        refuse |=> interrupt_request_out && !busy) else $error("not ready refusal");
    a_irq_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
        interrupt_request_out && status_read && !irq_set && !sticky_q
        |=> !interrupt_request_out) else $error("irq not cleared");
    a_irq_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
        interrupt_request_out && !status_read && !cmd_write |=> interrupt_request_out)
        else $error("irq dropped on its own");
    a_force_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
        take && is_force && cmd_data[3:0] == 4'h0 |=> !busy ##1 !interrupt_request_out)
        else $error("plain force raised irq");
    a_boot_restore: assert property (@(posedge sys_clk)
        !reset_n ##1 reset_n |=> cmd_kind == CMD_RESTORE && busy)
        else $error("no restore after reset");
    a_mark_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_kind == CMD_WR_SECT && cmd_q[0] |-> data_mark_select == MARK_DELETED)
        else $error("wrong data mark");

    c_seek_done: cover property (@(posedge sys_clk) disable iff (!reset_n)
        take && in_kind == CMD_SEEK ##[1:20] done);
    c_settle_run: cover property (@(posedge sys_clk) disable iff (!reset_n)
        state_q == ST_SETTLE ##1 state_q == ST_RUN);
    c_refused: cover property (@(posedge sys_clk) disable iff (!reset_n) refuse);
    c_force_abort: cover property (@(posedge sys_clk) disable iff (!reset_n)
        busy && take && is_force);
endmodule // dcd_decoder

// >>> testbench/dcd_exec_model.sv
// execution-side model that finishes each launched command after a delay
`timescale 1ns/10ps
module dcd_exec_model (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       op_start,
    input  wire logic [7:0] hold_cyc,
    input  wire logic       err_in,
    output logic            op_done,
    output logic            op_error
);
    logic [7:0] cnt_q; // cycles left before finish
    logic       run_q; // a command is being worked on
    // count down from launch, then pulse done for one cycle
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            run_q    <= 1'b0;
            cnt_q    <= 8'h00;
            op_done  <= 1'b0;
            op_error <= 1'b0;
        end
        else if (op_start)
        begin
            run_q   <= 1'b1;
            cnt_q   <= hold_cyc;
            op_done <= 1'b0;
        end
        else if (run_q && cnt_q == 8'h00)
        begin
            run_q    <= 1'b0;
            op_done  <= 1'b1;
            op_error <= err_in;
        end
        else
        begin
            // outside the done cycle the error line shows the inverse
            op_done  <= 1'b0;
            op_error <= ~err_in;
            cnt_q    <= cnt_q - 8'h01;
        end
    end
endmodule // dcd_exec_model

// >>> testbench/disk_controller_command_decoder_tb.sv
// self-checking bench for the disk command decoder
`timescale 1ns/10ps
module disk_controller_command_decoder_tb;
    import dcd_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, side_variant = 1'b0, cmd_write = 1'b0;
    logic status_read = 1'b0, ready_pin = 1'b1, index_pin = 1'b0, err_in = 1'b0;
    logic [7:0] cmd_data = 8'h00, hold_cyc = 8'h06;
    logic [1:0] id_length_code = 2'b00;
    logic op_done, op_error, busy, error_flag, irq, side_sel, op_start, trk_upd, verify_en;
    logic head_load, side_cmp, side_exp, multi, refused;
    logic [1:0] step_rate;
    logic [7:0] mark;
    logic [10:0] sector_bytes;
    dcd_cmd_type cmd_kind;
    dcd_class_type cmd_class;
    int err_total = 0, checks = 0;
    // command table: restore, seek, three steps, sector, track, address
    logic [7:0] cmds [12] = '{8'h00, 8'h1f, 8'h35, 8'h48, 8'h7a, 8'h9a, 8'ha9, 8'ha0,
                              8'hc0, 8'he0, 8'hf0, 8'h13};
    dcd_cmd_type kinds [12] = '{CMD_RESTORE, CMD_SEEK, CMD_STEP, CMD_STEP_IN, CMD_STEP_OUT,
        CMD_RD_SECT, CMD_WR_SECT, CMD_WR_SECT, CMD_RD_ADDR, CMD_RD_TRACK, CMD_WR_TRACK,
        CMD_SEEK};
    logic [10:0] lens [5] = '{LEN_128, LEN_256, LEN_512, LEN_1024, LEN_128};
    dcd_class_type cls;

    always #20 sys_clk = ~sys_clk; // 25 MHz

    dcd_decoder dcd_decoder_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .side_variant(side_variant), .cmd_write(cmd_write), .cmd_data(cmd_data),
        .status_read(status_read), .op_done(op_done), .op_error(op_error),
        .ready_pin(ready_pin), .index_pin(index_pin), .id_length_code(id_length_code),
        .busy(busy), .error_flag(error_flag), .interrupt_request_out(irq),
        .side_select_out(side_sel), .op_start(op_start), .cmd_kind(cmd_kind),
        .cmd_class(cmd_class), .step_rate(step_rate), .verify_en(verify_en),
        .head_load(head_load), .track_update(trk_upd), .data_mark_select(mark),
        .side_compare_en(side_cmp), .side_expected(side_exp), .multi_record(multi),
        .sector_bytes(sector_bytes), .not_ready_refused(refused));
    dcd_exec_model dcd_exec_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .op_start(op_start), .hold_cyc(hold_cyc), .err_in(err_in),
        .op_done(op_done), .op_error(op_error));

    // verdict and end of run
    task automatic end_of_test();
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // single-bit compare
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask
    // field compare
    task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: field got %h expected %h", $time, got, exp);
        end
    endtask
    // one command write cycle
    task automatic write_cmd(input logic [7:0] d);
        @(negedge sys_clk);
        cmd_write = 1'b1;
        cmd_data = d;
        @(negedge sys_clk);
        cmd_write = 1'b0;
    endtask
    // status read pulse, then let the clear land
    task automatic read_status();
        @(negedge sys_clk);
        status_read = 1'b1;
        @(negedge sys_clk);
        status_read = 1'b0;
        @(negedge sys_clk);
    endtask
    // bounded wait for the command to finish
    task automatic wait_idle();
        int n;
        for (n = 0; n < 500 && busy !== 1'b0; n++)
            @(negedge sys_clk);
        if (busy !== 1'b0)
        begin
            err_total++;
            $display("Error at %0t: busy never cleared", $time);
            end_of_test();
        end
    endtask
    // reset, then the automatic restore
    task automatic do_reset();
        @(negedge sys_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk_bit(irq, 1'b0);
        reset_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk_bit(busy, 1'b1);
        chk_val(11'(cmd_kind), 11'(CMD_RESTORE));
        chk_val(11'(step_rate), 11'h003);
        wait_idle();
        chk_bit(irq, 1'b1);
        read_status();
        chk_bit(irq, 1'b0);
    endtask

    initial
    begin
        do_reset();
        // every command code but force with its flags, compare variant
        for (int i = 0; i < 12; i++)
        begin
            cls = (i < 5 || i == 11) ? CLS_ONE : (i < 8 ? CLS_TWO : CLS_THREE);
            err_in = (i == 11);
            write_cmd(cmds[i]);
            chk_bit(irq, 1'b0);
            chk_bit(busy, 1'b1);
            chk_val(11'(cmd_kind), 11'(kinds[i]));
            chk_val(11'(cmd_class), 11'(cls));
            if (cls == CLS_ONE)
            begin
                chk_val(11'(step_rate), 11'(cmds[i][1:0]));
                chk_bit(verify_en, cmds[i][2]);
                chk_bit(head_load, cmds[i][3]);
                if (i >= 2 && i <= 4)
                    chk_bit(trk_upd, cmds[i][4]);
            end
            if (cls == CLS_TWO)
            begin
                chk_bit(multi, cmds[i][4]);
                chk_bit(side_cmp, cmds[i][1]);
                chk_bit(side_exp, cmds[i][3]);
                if (kinds[i] == CMD_WR_SECT)
                    chk_val(11'(mark),
                            cmds[i][0] ? 11'(MARK_DELETED) : 11'(MARK_NORMAL));
            end
            wait_idle();
            chk_bit(irq, 1'b1);
            chk_bit(error_flag, err_in);
        end
        err_in = 1'b0;
        // side-select variant: output follows bit 1, length table by bit 3
        side_variant = 1'b1;
        for (int l = 0; l < 2; l++)
        begin
            write_cmd(l ? 8'h88 : 8'h82);
            @(negedge sys_clk);
            chk_bit(side_sel, l == 0);
            for (int c = 0; c < 4; c++)
            begin
                id_length_code = 2'(c);
                @(negedge sys_clk);
                chk_val(sector_bytes, lens[l ? c : c + 1]);
            end
            wait_idle();
        end
        side_variant = 1'b0;
        // non-force write while busy ignored, then a plain force aborts
        hold_cyc = 8'h1e;
        write_cmd(8'h10);
        write_cmd(8'h80);
        chk_val(11'(cmd_kind), 11'(CMD_SEEK));
        write_cmd(8'hd0);
        @(negedge sys_clk);
        chk_bit(busy, 1'b0);
        chk_bit(irq, 1'b0);
        repeat (40) @(negedge sys_clk);
        hold_cyc = 8'h06;
        // settle request keeps busy with no start, a plain force ends it
        write_cmd(8'h84);
        repeat (50) @(negedge sys_clk);
        chk_bit(busy, 1'b1);
        chk_bit(op_start, 1'b0);
        write_cmd(8'hd0);
        chk_bit(busy, 1'b0);
        // armed ready fall and index conditions
        write_cmd(8'hd2);
        ready_pin = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk_bit(irq, 1'b1);
        read_status();
        // refusal of a track command while not ready; positioning still runs
        write_cmd(8'he0);
        repeat (3) @(negedge sys_clk);
        chk_bit(busy, 1'b0);
        chk_bit(irq, 1'b1);
        chk_bit(error_flag, 1'b1);
        chk_bit(refused, 1'b1);
        write_cmd(8'h00);
        chk_bit(busy, 1'b1);
        chk_bit(refused, 1'b0);
        wait_idle();
        ready_pin = 1'b1;
        read_status();
        write_cmd(8'hd4);
        repeat (3) @(negedge sys_clk);
        index_pin = 1'b1;
        repeat (3) @(negedge sys_clk);
        index_pin = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk_bit(irq, 1'b1);
        read_status();
        // immediate interrupt survives a status read, only reset clears it
        write_cmd(8'hd8);
        repeat (3) @(negedge sys_clk);
        read_status();
        chk_bit(irq, 1'b1);
        do_reset();
        end_of_test();
    end
endmodule // disk_controller_command_decoder_tb
